// >>> logic/msr_pkg.sv
// msr_pkg: constants and carriers for the miscellaneous system register bank
// assumes a simple byte-addressed register port driven by the management interface
package msr_pkg;
	localparam logic [8:0]  OFS_IDENT      = 9'h050; // chip_identity_revision
	localparam logic [8:0]  OFS_PROBE      = 9'h064; // endianness_probe
	localparam logic [8:0]  OFS_CONFIG     = 9'h074; // hardware_config_status
	localparam logic [8:0]  OFS_TIMER_CFG  = 9'h08c; // timer_config
	localparam logic [8:0]  OFS_TIMER_CNT  = 9'h090; // timer_count
	localparam logic [31:0] PROBE_PATTERN  = 32'h87654321;
	localparam logic [31:0] PROBE_INVALID  = 32'h00000000; // read during reset/not ready
	localparam logic [15:0] CHIP_ID        = 16'h0a5c; // arbitrary identity value
	localparam logic [15:0] CHIP_REV       = 16'h0001; // arbitrary revision value
	localparam logic [15:0] PRELOAD_RESET  = 16'hffff;
	localparam logic [15:0] COUNT_RESET    = 16'hffff;
	localparam int          READY_BIT      = 27;
	localparam int          STRAP2_BIT     = 26;
	localparam int          STRAP1_BIT     = 25;
	localparam int          TIMER_EN_BIT   = 29;
	localparam logic [7:0]  SETTLE_CYCLES  = 8'h10; // settle count at which ready sets: 17 cycles after digital reset release, 18 after system reset
	localparam logic [31:0] UNMAPPED_DATA  = 32'h00000000;

	// one register access request from the management interface
	typedef struct packed {
		logic        rd;   // read strobe
		logic        wr;   // write strobe
		logic [1:0]  half; // read lanes: 01 low half, 10 high half, 11 whole word
		logic [8:0]  addr; // byte offset
		logic [31:0] wdata;
	} msr_req_s;

	// register answer
	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} msr_rsp_s;
endpackage : msr_pkg

// >>> logic/msr_timer.sv
// msr_timer: 16-bit down-counting general purpose timer
// assumes preload and enable come from the register bank on the same clock
`timescale 1ns/1ps
`default_nettype none
module msr_timer (
	input  wire logic        ref_clk, // system clock
	input  wire logic        sys_rst, // async reset, active high
	input  wire logic        clear,   // synchronous clear on digital reset
	input  wire logic        run,     // timer enable
	input  wire logic [15:0] preload, // starting value
	output logic      [15:0] count,   // present value
	output logic             wrap     // pulse at zero crossing
);
	logic run_q; // previous enable, for start detection

	// load on start, count down while running, wrap from zero to all ones
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count <= msr_pkg::COUNT_RESET;
			run_q <= 1'b0;
			wrap  <= 1'b0;
		end
		else if (clear)
		begin
			count <= msr_pkg::COUNT_RESET;         // [R13]
			run_q <= 1'b0;
			wrap  <= 1'b0;
		end
		else
		begin
			run_q <= run;
			wrap  <= run && run_q && (count == 16'h0000); // [R14] [R16]
			if (run && !run_q)
				count <= preload;                  // [R12]
			else if (run)
				count <= count - 16'h0001;         // [R12] [R16]
		end
	end
endmodule : msr_timer
`default_nettype wire

// >>> logic/msr_regs.sv
// msr_regs: misc system register bank with identity, probe, config and timer
// assumes the management interface presents one request per cycle as msr_req_s
// How it works
// R1: identity word: fixed chip id high, revision low, read only.
// R2: probe register returns the constant byte-order pattern once ready and out of digital reset.
// R3: probe readable while not ready; returns a non-pattern value in reset.
// R4: either half of probe or config word readable on its own.
// R5: ready bit 27 resets to zero, sets after a settle count.
// R6: every register is readable before ready; timer config writes before ready are dropped.
// R7: config word readable during reset and not ready states.
// R8: bit 26 shows port 2 crossover strap caught at system reset release, until the loader rewrites it.
// R9: bit 25 shows port 1 crossover strap caught at system reset release, until the loader rewrites it.
// R10: timer enable bit, reset zero, runs or halts the timer.
// R11: enable falling from one to zero forces preload to all ones.
// R12: preload field resets to all ones and gives the start value.
// R13: count register shows present timer value low, upper bits zero.
// R14: timer raises an event at each wrap; only the first follows the preload, later ones come every 65536 counts.
// R15: after digital reset, host polls probe until the pattern returns.
// R16: count reaching zero flags an event and wraps to all ones.
`timescale 1ns/1ps
`default_nettype none
module msr_regs (
	input  wire logic             ref_clk,     // system clock
	input  wire logic             sys_rst,     // async reset, active high
	input  wire logic             digital_rst, // digital reset request, active high
	input  wire logic             strap_mdix1, // port 1 crossover strap level
	input  wire logic             strap_mdix2, // port 2 crossover strap level
	input  wire logic             loader_we,   // configuration loader rewrite strobe
	input  wire logic [1:0]       loader_strap,// loader values: [1] port 2, [0] port 1
	input  wire msr_pkg::msr_req_s req,        // register request
	output msr_pkg::msr_rsp_s     rsp,         // register answer, one cycle later
	output logic                  mdix1_out,   // crossover state to port 1 phy
	output logic                  mdix2_out,   // crossover state to port 2 phy
	output logic                  timer_event  // one-cycle timer event pulse
);
	typedef enum logic [1:0] {MSR_ST_CAPTURE, MSR_ST_SETTLE, MSR_ST_READY} msr_state_e;

	msr_state_e  state;
	logic [7:0]  settle;
	logic        ready;
	logic        strap1;
	logic        strap2;
	logic        timer_en;
	logic [15:0] preload;
	logic [15:0] count;
	logic        wrap;

	// half-word lane selection shared by split-readable words
	function automatic logic [31:0] lanes(input logic [31:0] w, input logic [1:0] h);
		lanes = {(h[1] ? w[31:16] : 16'h0000), (h[0] ? w[15:0] : 16'h0000)};
	endfunction : lanes

	// address decode and register images
	wire hit_id    = (req.addr == msr_pkg::OFS_IDENT);
	wire hit_probe = (req.addr == msr_pkg::OFS_PROBE);
	wire hit_cfg   = (req.addr == msr_pkg::OFS_CONFIG);
	wire hit_tcfg  = (req.addr == msr_pkg::OFS_TIMER_CFG);
	wire hit_tcnt  = (req.addr == msr_pkg::OFS_TIMER_CNT);
	wire in_reset  = digital_rst;
	wire [31:0] id_word    = {msr_pkg::CHIP_ID, msr_pkg::CHIP_REV};                 // [R1]
	wire [31:0] probe_word = (ready && !in_reset) ? msr_pkg::PROBE_PATTERN
	                                              : msr_pkg::PROBE_INVALID;         // [R2] [R3]
	wire [31:0] cfg_word   = {4'h0, ready, strap2, strap1, 25'h0000000};           // [R5] [R7]
	wire [31:0] tcfg_word  = {2'b00, timer_en, 13'h0000, preload};
	wire [31:0] tcnt_word  = {16'h0000, count};                                     // [R13]
	wire [31:0] rd_mux = hit_id    ? id_word :
	                     hit_probe ? lanes(probe_word, req.half) :                  // [R4]
	                     hit_cfg   ? lanes(cfg_word, req.half) :                    // [R4]
	                     hit_tcfg  ? tcfg_word :
	                     hit_tcnt  ? tcnt_word : msr_pkg::UNMAPPED_DATA;
	wire wr_tcfg = req.wr && hit_tcfg && ready && !in_reset;                        // [R6]
	wire next_en = wr_tcfg ? req.wdata[msr_pkg::TIMER_EN_BIT] : timer_en;
	wire fall_en = timer_en && !next_en;

	// system reset release: catch straps, then settle before ready; digital reset release goes straight to settle
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state  <= MSR_ST_CAPTURE;
			settle <= 8'h00;
			ready  <= 1'b0;
			strap1 <= 1'b0;
			strap2 <= 1'b0;
		end
		else if (digital_rst)
		begin
			state  <= MSR_ST_SETTLE;
			settle <= 8'h00;
			ready  <= 1'b0;                                    // [R5]
		end
		else
		begin
			case (state)
				MSR_ST_CAPTURE:
				begin
					strap1 <= strap_mdix1;                     // [R9]
					strap2 <= strap_mdix2;                     // [R8]
					state  <= MSR_ST_SETTLE;
				end
				MSR_ST_SETTLE:
				begin
					settle <= settle + 8'h01;
					if (settle == msr_pkg::SETTLE_CYCLES)
					begin
						ready <= 1'b1;                         // [R5]
						state <= MSR_ST_READY;
					end
				end
				MSR_ST_READY:
				begin
					if (loader_we)
					begin
						strap1 <= loader_strap[0];             // [R9]
						strap2 <= loader_strap[1];             // [R8]
					end
				end
				default: state <= MSR_ST_CAPTURE;
			endcase
		end
	end

	// timer configuration register
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timer_en <= 1'b0;                                  // [R10]
			preload  <= msr_pkg::PRELOAD_RESET;                // [R12]
		end
		else if (digital_rst)
		begin
			timer_en <= 1'b0;
			preload  <= msr_pkg::PRELOAD_RESET;
		end
		else
		begin
			timer_en <= next_en;                               // [R10]
			if (fall_en)
				preload <= msr_pkg::PRELOAD_RESET;             // [R11]
			else if (wr_tcfg)
				preload <= req.wdata[15:0];                    // [R12]
		end
	end

	// read answer and registered outputs
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rsp         <= '0;
			mdix1_out   <= 1'b0;
			mdix2_out   <= 1'b0;
			timer_event <= 1'b0;
		end
		else
		begin
			rsp.valid   <= req.rd;
			rsp.rdata   <= req.rd ? rd_mux : 32'h00000000;
			mdix1_out   <= strap1;
			mdix2_out   <= strap2;
			timer_event <= wrap;                               // [R14] [R16]
		end
	end

	msr_timer u_timer (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.clear   (digital_rst),
		.run     (timer_en && !digital_rst),
		.preload (preload),
		.count   (count),
		.wrap    (wrap)
	);

	// checks
	property p_ready_reset;
		@(posedge ref_clk) disable iff (sys_rst) digital_rst |=> !ready;
	endproperty
	a_ready_reset: assert property (p_ready_reset) else $error("ready not cleared"); // [R5]

	property p_probe;
		@(posedge ref_clk) disable iff (sys_rst)
		(req.rd && hit_probe && req.half == 2'b11 && ready && !digital_rst)
		|=> (rsp.valid && rsp.rdata == msr_pkg::PROBE_PATTERN);
	endproperty
	a_probe: assert property (p_probe) else $error("probe pattern wrong"); // [R2]

	property p_probe_notready;
		@(posedge ref_clk) disable iff (sys_rst)
		(req.rd && hit_probe && !ready) |=> rsp.rdata != msr_pkg::PROBE_PATTERN;
	endproperty
	a_probe_notready: assert property (p_probe_notready) else $error("pattern while not ready"); // [R3]

	property p_half;
		@(posedge ref_clk) disable iff (sys_rst)
		(req.rd && hit_cfg && req.half == 2'b10) |=> rsp.rdata[15:0] == 16'h0000;
	endproperty
	a_half: assert property (p_half) else $error("low half leaked"); // [R4]

	property p_fall;
		@(posedge ref_clk) disable iff (sys_rst)
		(timer_en && !next_en) |=> preload == msr_pkg::PRELOAD_RESET;
	endproperty
	a_fall: assert property (p_fall) else $error("preload not forced"); // [R11]

	property p_id;
		@(posedge ref_clk) disable iff (sys_rst)
		(req.rd && hit_id) |=> rsp.rdata == {msr_pkg::CHIP_ID, msr_pkg::CHIP_REV};
	endproperty
	a_id: assert property (p_id) else $error("identity word wrong"); // [R1]

	property p_count;
		@(posedge ref_clk) disable iff (sys_rst)
		(req.rd && hit_tcnt) |=> rsp.rdata == {16'h0000, $past(count)};
	endproperty
	a_count: assert property (p_count) else $error("count read wrong"); // [R13]

	sequence s_zero;
		timer_en && !digital_rst && count == 16'h0000 && $past(timer_en);
	endsequence
	property p_wrap;
		@(posedge ref_clk) disable iff (sys_rst)
		s_zero |=> (count == 16'hffff) ##1 timer_event;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap or event missing"); // [R16]

	property p_halt;
		@(posedge ref_clk) disable iff (sys_rst)
		(!timer_en && !$past(timer_en) && !digital_rst) |=> $stable(count);
	endproperty
	a_halt: assert property (p_halt) else $error("count moved while halted"); // [R10]

	// a read is answered on the next edge
	property p_answer;
		@(posedge ref_clk) disable iff (sys_rst)
		req.rd |=> rsp.valid;
	endproperty
	a_answer: assert property (p_answer) else $error("read not answered"); // [R7]

	// config word: ready shown at its bit, reserved bits read zero
	property p_cfg_bits;
		@(posedge ref_clk) disable iff (sys_rst)
		(req.rd && hit_cfg && req.half == 2'b11)
		|=> (rsp.rdata[msr_pkg::READY_BIT] == $past(ready)
		&& rsp.rdata[31:28] == 4'h0 && rsp.rdata[24:0] == 25'h0000000);
	endproperty
	a_cfg_bits: assert property (p_cfg_bits) else $error("config word bits wrong"); // [R5]

	// straps follow the pins once at capture, then only the loader
	property p_capture;
		@(posedge ref_clk) disable iff (sys_rst)
		(state == MSR_ST_CAPTURE && !digital_rst)
		|=> (strap1 == $past(strap_mdix1) && strap2 == $past(strap_mdix2));
	endproperty
	a_capture: assert property (p_capture) else $error("strap not captured"); // [R8] [R9]

	property p_loader;
		@(posedge ref_clk) disable iff (sys_rst)
		(state == MSR_ST_READY && loader_we && !digital_rst)
		|=> (strap1 == $past(loader_strap[0]) && strap2 == $past(loader_strap[1]));
	endproperty
	a_loader: assert property (p_loader) else $error("loader value not taken"); // [R9]

	property p_strap_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		(state != MSR_ST_CAPTURE && !(state == MSR_ST_READY && loader_we))
		|=> ($stable(strap1) && $stable(strap2));
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap changed"); // [R8]

	// ready, once set, holds until the next digital reset
	property p_ready_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		(ready && !digital_rst) |=> ready;
	endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("ready dropped"); // [R5]

	// writes before ready leave the timer settings alone
	property p_refused;
		@(posedge ref_clk) disable iff (sys_rst)
		(req.wr && hit_tcfg && !ready && !digital_rst)
		|=> ($stable(timer_en) && $stable(preload));
	endproperty
	a_refused: assert property (p_refused) else $error("write taken before ready"); // [R6]

	// enable rising loads the preload, then one step down per edge
	sequence s_start;
		!timer_en ##1 (timer_en && !digital_rst);
	endsequence
	property p_load;
		@(posedge ref_clk) disable iff (sys_rst)
		s_start |=> count == $past(preload);
	endproperty
	a_load: assert property (p_load) else $error("preload not loaded"); // [R12]

	sequence s_running;
		timer_en ##1 (timer_en && !digital_rst && count != 16'h0000);
	endsequence
	property p_down;
		@(posedge ref_clk) disable iff (sys_rst)
		s_running |=> count == $past(count) - 16'h0001;
	endproperty
	a_down: assert property (p_down) else $error("count did not step down"); // [R12]

	// the timer event is a single-cycle pulse
	property p_pulse;
		@(posedge ref_clk) disable iff (sys_rst)
		timer_event |=> !timer_event;
	endproperty
	a_pulse: assert property (p_pulse) else $error("event longer than one cycle"); // [R14]
endmodule : msr_regs
`default_nettype wire

// >>> tb/msr_host.sv
// msr_host: host model issuing register reads and writes to the bank
// assumes a read is answered at the edge that takes it
`timescale 1ns/1ps
`default_nettype none
module msr_host (
	input  wire logic              ref_clk, // system clock
	input  wire msr_pkg::msr_rsp_s rsp,     // register answer
	output var msr_pkg::msr_req_s  req      // register request
);
	initial req = '0;

	// one request held for one edge, then the idle bus shows its inverse
	task automatic go(input logic r, input logic w, input logic [1:0] h,
		input logic [8:0] a, input logic [31:0] dat);
		@(posedge ref_clk);
		req <= '{rd: r, wr: w, half: h, addr: a, wdata: dat};
		@(posedge ref_clk);
		req <= '{rd: 1'b0, wr: 1'b0, half: ~h, addr: ~a, wdata: ~dat};
	endtask : go

	// read answer sampled settled, half a cycle after the taking edge
	task automatic rd(input logic [8:0] a, input logic [1:0] h, output logic [31:0] dat);
		go(1'b1, 1'b0, h, a, 32'h0);
		@(negedge ref_clk);
		dat = rsp.rdata;
	endtask : rd

	task automatic wr(input logic [8:0] a, input logic [31:0] dat);
		go(1'b0, 1'b1, 2'h3, a, dat);
	endtask : wr
endmodule : msr_host
`default_nettype wire

// >>> tb/msr_regs_test.sv
// msr_regs_test: self-checking bench for the system register bank
// assumes the host model above and the package constants
`timescale 1ns/1ps
`default_nettype none
module msr_regs_test;
	logic              ref_clk;
	logic              sys_rst;
	logic              digital_rst;
	logic [1:0]        loader_strap;
	logic              loader_we;
	msr_pkg::msr_req_s req;
	msr_pkg::msr_rsp_s rsp;
	logic              mdix1_out;
	logic              mdix2_out;
	logic              timer_event;
	logic [31:0]       d;
	logic [31:0]       held;
	logic              strap_p1;
	logic              strap_p2;
	int                errors = 0;
	int                checked = 0;
	int                n;

	msr_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .digital_rst(digital_rst),
		.strap_mdix1(strap_p1), .strap_mdix2(strap_p2), .loader_we(loader_we),
		.loader_strap(loader_strap), .req(req), .rsp(rsp), .mdix1_out(mdix1_out),
		.mdix2_out(mdix2_out), .timer_event(timer_event));
	msr_host host_u (.ref_clk(ref_clk), .rsp(rsp), .req(req));

	// 100 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// read one register and compare
	task automatic rchk(input logic [8:0] a, input logic [1:0] h, input logic [31:0] exp);
		host_u.rd(a, h, d);
		chk(d, exp);
	endtask : rchk

	// poll the probe until the pattern shows, no other reads meanwhile
	task automatic wait_ready(input logic [31:0] cfg_exp);
		n = 0;
		host_u.rd(msr_pkg::OFS_PROBE, 2'h3, d);
		chk({31'h0, d === msr_pkg::PROBE_PATTERN}, 32'h0);
		while (d !== msr_pkg::PROBE_PATTERN && n < 40)
		begin
			host_u.rd(msr_pkg::OFS_PROBE, 2'h3, d);
			n++;
		end
		chk(d, msr_pkg::PROBE_PATTERN);
		rchk(msr_pkg::OFS_CONFIG, 2'h3, cfg_exp);
	endtask : wait_ready

	// reset values, identity, probe halves, unmapped read
	task automatic t_reset;
		host_u.rd(msr_pkg::OFS_PROBE, 2'h3, d);
		chk({31'h0, d === msr_pkg::PROBE_PATTERN}, 32'h0);
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		rchk(msr_pkg::OFS_CONFIG, 2'h3, 32'h02000000);
		// strap pins move after capture; the latched states must not
		@(posedge ref_clk);
		strap_p1 <= 1'b0;
		strap_p2 <= 1'b1;
		wait_ready(32'h0a000000);
		rchk(msr_pkg::OFS_IDENT, 2'h3, {msr_pkg::CHIP_ID, msr_pkg::CHIP_REV});
		rchk(msr_pkg::OFS_PROBE, 2'h3, 32'h87654321);
		host_u.rd(msr_pkg::OFS_PROBE, 2'h1, d);
		chk({16'h0, d[15:0]}, 32'h4321);
		host_u.rd(msr_pkg::OFS_PROBE, 2'h2, d);
		chk({16'h0, d[31:16]}, 32'h8765);
		host_u.rd(msr_pkg::OFS_CONFIG, 2'h2, d);
		chk({16'h0, d[31:16]}, 32'h0a00);
		rchk(msr_pkg::OFS_TIMER_CFG, 2'h3, 32'h0000ffff);
		rchk(msr_pkg::OFS_TIMER_CNT, 2'h3, 32'h0000ffff);
		rchk(9'h100, 2'h3, 32'h0);
	endtask : t_reset

	// run from preload 5, event at the wrap, then halt and forced preload
	// count wraps to ffff and halts five steps later at fffa
	task automatic t_timer;
		host_u.wr(msr_pkg::OFS_TIMER_CFG, 32'h20000005);
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (timer_event !== 1'b1 && n < 30);
		chk(n, 9);
		rchk(msr_pkg::OFS_TIMER_CFG, 2'h3, 32'h20000005);
		host_u.wr(msr_pkg::OFS_TIMER_CFG, 32'h00000005);
		rchk(msr_pkg::OFS_TIMER_CFG, 2'h3, 32'h0000ffff);
		host_u.rd(msr_pkg::OFS_TIMER_CNT, 2'h3, held);
		chk(held, 32'h0000fffa);
		rchk(msr_pkg::OFS_TIMER_CNT, 2'h3, held);
	endtask : t_timer

	// loader rewrites both strap states
	task automatic t_loader;
		@(posedge ref_clk);
		loader_strap <= 2'b10;
		loader_we <= 1'b1;
		@(posedge ref_clk);
		loader_we <= 1'b0;
		rchk(msr_pkg::OFS_CONFIG, 2'h3, 32'h0c000000);
		chk({30'h0, mdix2_out, mdix1_out}, 32'h2);
	endtask : t_loader

	// digital reset clears ready and timer, an early write is dropped
	task automatic t_digital;
		host_u.wr(msr_pkg::OFS_TIMER_CFG, 32'h00001234);
		rchk(msr_pkg::OFS_TIMER_CFG, 2'h3, 32'h00001234);
		@(posedge ref_clk);
		digital_rst <= 1'b1;
		@(posedge ref_clk);
		digital_rst <= 1'b0;
		// deliberately early write, must leave no trace
		host_u.wr(msr_pkg::OFS_TIMER_CFG, 32'h20005678);
		wait_ready(32'h0c000000);
		rchk(msr_pkg::OFS_TIMER_CFG, 2'h3, 32'h0000ffff);
		rchk(msr_pkg::OFS_TIMER_CNT, 2'h3, 32'h0000ffff);
	endtask : t_digital

	task automatic complete_run;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	// watchdog well past the expected run
	initial
	begin
		#200us;
		errors++;
		complete_run();
	end

	initial
	begin
		sys_rst = 1'b1;
		digital_rst = 1'b0;
		loader_we = 1'b0;
		loader_strap = 2'b00;
		strap_p1 = 1'b1;
		strap_p2 = 1'b0;
		t_reset();
		t_timer();
		t_loader();
		t_digital();
		complete_run();
	end
endmodule : msr_regs_test
`default_nettype wire
